// file: pkg/cfh_pkg.sv
// Purpose: shared constants and types of the configuration frame handler
// Assumes: byte framer strips parity and crc and flags good frames
// Notes:   apb offsets are byte addresses, one 32-bit word each
//
// How it works
// - readback status is 0x0 when the eeprom is busy and refused access, 0x1 when busy mid-transfer.
// - readback status is 0x2 when idle after a good transfer, 0x3 when idle after a failed one.
// - a broadcast flag of 1 addresses all nodes, 0 addresses only the node named in the header.
// - the addressing enable frame is obeyed only in otp setup and ignored in all other states.
// - the assign frame carries the new 5-bit node address in the low bits of its first data byte.
// - the assign frame carries an 8-bit threshold that decides whether the node takes the address.
// - the assign frame is obeyed only in the auto-addressing state and discarded otherwise.
// - a 4-bit tally of valid frames goes out beside the 4-bit state code in the state report.
// - the tally rises by one per valid frame processed; invalid frames leave it alone.
// - the tally wraps from its maximum to zero.
// - state code is 0x4 normal direct, 0x5 normal pwm, 0x6 normal fail-safe on otp defaults.
// - state code is 0x7 in normal fail-safe with all switches open.
// - state code is 0xe in fail-safe on otp settings and 0xf in fail-safe with switches open.
// - state code is 0xc in unchecked-frame direct mode and 0xd in unchecked-frame pwm mode.

package cfh_pkg;

  // frame selectors
  localparam logic [4:0] SEL_READBACK = 5'h03;
  localparam logic [4:0] SEL_AA_EN    = 5'h04;
  localparam logic [4:0] SEL_ASSIGN   = 5'h05;
  localparam logic [4:0] SEL_STATE    = 5'h06;

  // data byte counts without crc, header included
  localparam logic [3:0] LEN_REQUEST  = 4'h2;
  localparam logic [3:0] LEN_AA_EN    = 4'h3;
  localparam logic [3:0] LEN_ASSIGN   = 4'h4;
  localparam logic [3:0] LEN_READBACK = 4'hc;
  localparam logic [3:0] LEN_STATE    = 4'h3;

  // field positions
  localparam int BCAST_BIT  = 7;
  localparam int AAC_BIT    = 0;
  localparam int WP_BIT     = 7;
  localparam int EES_LSB    = 5;
  localparam logic [1:0] HEADER_BYTE_ONE_FIXED = 2'h3;
  localparam logic [1:0] HEADER_BYTE_TWO_FIXED = 2'h0;

  // eeprom status codes
  localparam logic [1:0] EE_DENIED  = 2'h0;
  localparam logic [1:0] EE_ONGOING = 2'h1;
  localparam logic [1:0] EE_DONE    = 2'h2;
  localparam logic [1:0] EE_FAILED  = 2'h3;

  // operating state codes
  localparam logic [3:0] OP_NONE        = 4'h0;
  localparam logic [3:0] OP_OTP_SETUP   = 4'h1;
  localparam logic [3:0] OP_AUTO_ADDR   = 4'h2;
  localparam logic [3:0] OP_DIRECT      = 4'h4;
  localparam logic [3:0] OP_PWM         = 4'h5;
  localparam logic [3:0] OP_N_FS_OTP    = 4'h6;
  localparam logic [3:0] OP_N_FS_OPEN   = 4'h7;
  localparam logic [3:0] OP_NC_DIRECT   = 4'hc;
  localparam logic [3:0] OP_NC_PWM      = 4'hd;
  localparam logic [3:0] OP_FS_OTP      = 4'he;
  localparam logic [3:0] OP_FS_OPEN     = 4'hf;

  // mode index driven by the mode state machine
  typedef enum logic [3:0] {
    MODE_NONE      = 4'h0,
    MODE_OTP_SETUP = 4'h1,
    MODE_AUTO_ADDR = 4'h2,
    MODE_DIRECT    = 4'h3,
    MODE_PWM       = 4'h4,
    MODE_N_FS_OTP  = 4'h5,
    MODE_N_FS_OPEN = 4'h6,
    MODE_NC_DIRECT = 4'h7,
    MODE_NC_PWM    = 4'h8,
    MODE_FS_OTP    = 4'h9,
    MODE_FS_OPEN   = 4'ha
  } mode_e;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } tx_e;

  // apb register map
  localparam logic [11:0] REG_CTRL       = 12'h000;
  localparam logic [11:0] REG_NODE       = 12'h004;
  localparam logic [11:0] REG_THRESH     = 12'h008;
  localparam logic [11:0] REG_STATUS     = 12'h00c;
  localparam logic [11:0] REG_IRQ_STATUS = 12'h010;
  localparam logic [11:0] REG_IRQ_CLEAR  = 12'h014;
  localparam logic [11:0] REG_IRQ_ENABLE = 12'h018;

  localparam logic [4:0]  RST_NODE   = 5'h00;
  localparam logic [7:0]  RST_THRESH = 8'h00;
  localparam logic        RST_ENABLE = 1'b1;

  // status register fields
  localparam int ST_CODE_LSB  = 0;
  localparam int ST_TALLY_LSB = 4;
  localparam int ST_EES_LSB   = 8;
  localparam int ST_AA_BIT    = 10;
  localparam int ST_TX_BIT    = 11;
  localparam int ST_WP_BIT    = 12;

  // event bits
  localparam int NUM_EVENTS = 5;
  localparam int EV_FRAME   = 0;
  localparam int EV_AA      = 1;
  localparam int EV_TAKEN   = 2;
  localparam int EV_IGNORED = 3;
  localparam int EV_SENT    = 4;

endpackage

// file: src/sticky_event_bit.sv
// Purpose: one sticky interrupt status bit
// Assumes: set and clear are single-cycle pulses on pclk
// Notes:   set wins over a clear in the same cycle
`timescale 1ns/10ps

module sticky_event_bit
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic set_pulse,
  input  wire logic clear_pulse,
  output logic      flag
);

  typedef struct packed {
    logic flag;
  } state_s;

  state_s r;
  state_s next_r;

  always_comb
  begin
    next_r = r;
    if (set_pulse)
    begin
      next_r.flag = 1'b1;
    end
    else if (clear_pulse)
    begin
      next_r.flag = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
    end
    else if (clk_en)
    begin
      r <= next_r;
    end
  end

  assign flag = r.flag;

endmodule

// file: src/config_frame_handler.sv
// Purpose: decode and answer the eeprom readback, addressing enable,
//          address assign and state report configuration frames
// Assumes: framer on pclk delivers bytes without crc, flags good frames
// Notes:   apb slave answers in the first access cycle
`timescale 1ns/10ps

module config_frame_handler
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               clk_en,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               rx_valid,
  input  wire logic [7:0]         rx_data,
  input  wire logic               rx_last,
  input  wire logic               rx_good,
  output logic                    tx_valid,
  output logic [7:0]              tx_data,
  output logic                    tx_last,
  input  wire logic               tx_ready,
  input  wire logic               ee_busy,
  input  wire logic               ee_denied,
  input  wire logic               ee_failed,
  input  wire logic               ee_wp,
  input  wire logic [2:0]         eeprom_device_select,
  input  wire logic [7:0]         eeprom_byte_pointer,
  input  wire logic [63:0]        ee_bytes,
  input  wire logic [3:0]         mode_index,
  input  wire logic [7:0]         aa_level,
  output logic                    auto_address_switch,
  output logic [4:0]              assigned_node_address,
  output logic [7:0]              auto_address_threshold,
  output logic                    address_taken,
  output logic                    irq
);

  if (ADDR_W < 5)
  begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  typedef struct packed {
    logic [3:0]       rx_idx;
    logic [3:0][7:0]  rx_hdr;
    logic             enable;
    logic [4:0]       node_addr;
    logic [7:0]       threshold;
    logic             aa_switch;
    logic [3:0]       tally;
    cfh_pkg::tx_e     tx_state;
    logic [11:0][7:0] tx_buf;
    logic [3:0]       tx_len;
    logic [3:0]       tx_idx;
    logic             tx_valid;
    logic [7:0]       tx_data;
    logic             tx_last;
    logic [cfh_pkg::NUM_EVENTS-1:0] irq_en;
    logic             irq;
    logic             taken;
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
  } state_s;

  state_s r;
  state_s next_r;

  logic [cfh_pkg::NUM_EVENTS-1:0] ev;
  logic [cfh_pkg::NUM_EVENTS-1:0] ev_clear;
  logic [cfh_pkg::NUM_EVENTS-1:0] ev_flag;

  function automatic logic [3:0] state_code(input logic [3:0] m);
    case (m)
      cfh_pkg::MODE_OTP_SETUP: state_code = cfh_pkg::OP_OTP_SETUP;
      cfh_pkg::MODE_AUTO_ADDR: state_code = cfh_pkg::OP_AUTO_ADDR;
      cfh_pkg::MODE_DIRECT:    state_code = cfh_pkg::OP_DIRECT;
      cfh_pkg::MODE_PWM:       state_code = cfh_pkg::OP_PWM;
      cfh_pkg::MODE_N_FS_OTP:  state_code = cfh_pkg::OP_N_FS_OTP;
      cfh_pkg::MODE_N_FS_OPEN: state_code = cfh_pkg::OP_N_FS_OPEN;
      cfh_pkg::MODE_NC_DIRECT: state_code = cfh_pkg::OP_NC_DIRECT;
      cfh_pkg::MODE_NC_PWM:    state_code = cfh_pkg::OP_NC_PWM;
      cfh_pkg::MODE_FS_OTP:    state_code = cfh_pkg::OP_FS_OTP;
      cfh_pkg::MODE_FS_OPEN:   state_code = cfh_pkg::OP_FS_OPEN;
      default:                 state_code = cfh_pkg::OP_NONE;
    endcase
  endfunction

  logic [3:0]      op_code;
  logic [1:0]      eeprom_status_code;
  logic [3:0][7:0] fb;
  logic [3:0]      rx_len;
  logic            frame_done;
  logic            bcast;
  logic            addressed;
  logic            to_us;
  logic [4:0]      config_frame_selector;
  logic [7:0]      header_byte_one;
  logic [7:0]      header_byte_two;
  logic            apb_setup;
  logic            apb_write;
  logic [31:0]     status_word;
  logic [31:0]     rd_word;
  logic            rd_hit;

  always_comb
  begin
    op_code = state_code(mode_index);
    // denied only means something while busy
    if (ee_busy)
    begin
      eeprom_status_code = ee_denied ? cfh_pkg::EE_DENIED
                                     : cfh_pkg::EE_ONGOING;
    end
    else
    begin
      eeprom_status_code = ee_failed ? cfh_pkg::EE_FAILED
                                     : cfh_pkg::EE_DONE;
    end
  end

  // frame view with the byte arriving now laid over the stored ones
  always_comb
  begin
    fb = r.rx_hdr;
    if (r.rx_idx < 4'h4)
    begin
      fb[r.rx_idx[1:0]] = rx_data;
    end
    rx_len = r.rx_idx + 4'h1;
    frame_done = rx_valid && rx_last && rx_good;
    config_frame_selector = fb[1][4:0];
    bcast = fb[2][cfh_pkg::BCAST_BIT];
    addressed = (fb[0][4:0] == r.node_addr);
    to_us = bcast || addressed;
    header_byte_one = {1'b0, cfh_pkg::HEADER_BYTE_ONE_FIXED, r.node_addr};
    header_byte_two = {1'b0, cfh_pkg::HEADER_BYTE_TWO_FIXED, config_frame_selector};
  end

  always_comb
  begin
    status_word = '0;
    status_word[cfh_pkg::ST_CODE_LSB +: 4] = op_code;
    status_word[cfh_pkg::ST_TALLY_LSB +: 4] = r.tally;
    status_word[cfh_pkg::ST_EES_LSB +: 2] = eeprom_status_code;
    status_word[cfh_pkg::ST_AA_BIT] = r.aa_switch;
    status_word[cfh_pkg::ST_TX_BIT] = (r.tx_state == cfh_pkg::TX_SEND);
    status_word[cfh_pkg::ST_WP_BIT] = ee_wp;
    apb_setup = psel && !penable;
    apb_write = psel && penable && r.pready && pwrite;
    rd_word = '0;
    rd_hit = 1'b1;
    if (paddr == ADDR_W'(cfh_pkg::REG_CTRL))
    begin
      rd_word[0] = r.enable;
    end
    else if (paddr == ADDR_W'(cfh_pkg::REG_NODE))
    begin
      rd_word[4:0] = r.node_addr;
    end
    else if (paddr == ADDR_W'(cfh_pkg::REG_THRESH))
    begin
      rd_word[7:0] = r.threshold;
    end
    else if (paddr == ADDR_W'(cfh_pkg::REG_STATUS))
    begin
      rd_word = status_word;
    end
    else if (paddr == ADDR_W'(cfh_pkg::REG_IRQ_STATUS))
    begin
      rd_word[cfh_pkg::NUM_EVENTS-1:0] = ev_flag;
    end
    else if (paddr == ADDR_W'(cfh_pkg::REG_IRQ_CLEAR))
    begin
      rd_word = '0;
    end
    else if (paddr == ADDR_W'(cfh_pkg::REG_IRQ_ENABLE))
    begin
      rd_word[cfh_pkg::NUM_EVENTS-1:0] = r.irq_en;
    end
    else
    begin
      rd_hit = 1'b0;
    end
  end

  always_comb
  begin
    next_r = r;
    ev = '0;
    ev_clear = '0;
    next_r.taken = 1'b0;

    // apb: ready in the first access cycle, effects on that edge
    next_r.pready = apb_setup;
    next_r.pslverr = apb_setup && !rd_hit;
    if (apb_setup)
    begin
      next_r.prdata = pwrite ? 32'h0000_0000 : rd_word;
    end
    if (apb_write && !r.pslverr)
    begin
      if (paddr == ADDR_W'(cfh_pkg::REG_CTRL))
      begin
        next_r.enable = pwdata[0];
      end
      else if (paddr == ADDR_W'(cfh_pkg::REG_NODE))
      begin
        next_r.node_addr = pwdata[4:0];
      end
      else if (paddr == ADDR_W'(cfh_pkg::REG_IRQ_CLEAR))
      begin
        ev_clear = pwdata[cfh_pkg::NUM_EVENTS-1:0];
      end
      else if (paddr == ADDR_W'(cfh_pkg::REG_IRQ_ENABLE))
      begin
        next_r.irq_en = pwdata[cfh_pkg::NUM_EVENTS-1:0];
      end
    end

    // byte collection; only the first four bytes matter here
    if (rx_valid)
    begin
      if (r.rx_idx < 4'h4)
      begin
        next_r.rx_hdr[r.rx_idx[1:0]] = rx_data;
      end
      if (rx_last)
      begin
        next_r.rx_idx = 4'h0;
      end
      else if (r.rx_idx != 4'hf)
      begin
        next_r.rx_idx = r.rx_idx + 4'h1;
      end
    end

    // transmit side
    if (r.tx_valid && tx_ready)
    begin
      if (r.tx_last)
      begin
        next_r.tx_valid = 1'b0;
        next_r.tx_last = 1'b0;
        next_r.tx_state = cfh_pkg::TX_IDLE;
        ev[cfh_pkg::EV_SENT] = 1'b1;
      end
      else
      begin
        next_r.tx_data = r.tx_buf[r.tx_idx];
        next_r.tx_last = (r.tx_idx == r.tx_len - 4'h1);
        next_r.tx_idx = r.tx_idx + 4'h1;
      end
    end

    if (frame_done)
    begin
      next_r.tally = r.tally + 4'h1;
      ev[cfh_pkg::EV_FRAME] = 1'b1;
    end

    // a stopped handler still counts frames but answers none
    if (frame_done && r.enable)
    begin
      case (config_frame_selector)
        cfh_pkg::SEL_AA_EN:
        begin
          if (rx_len == cfh_pkg::LEN_AA_EN && to_us)
          begin
            if (mode_index == cfh_pkg::MODE_OTP_SETUP)
            begin
              next_r.aa_switch = fb[2][cfh_pkg::AAC_BIT];
              ev[cfh_pkg::EV_AA] = 1'b1;
            end
            else
            begin
              ev[cfh_pkg::EV_IGNORED] = 1'b1;
            end
          end
        end
        cfh_pkg::SEL_ASSIGN:
        begin
          if (rx_len == cfh_pkg::LEN_ASSIGN && to_us)
          begin
            if (mode_index == cfh_pkg::MODE_AUTO_ADDR)
            begin
              next_r.threshold = fb[3];
              // only nodes at or over the threshold take the offer
              if (aa_level >= fb[3])
              begin
                next_r.node_addr = fb[2][4:0];
                next_r.taken = 1'b1;
                ev[cfh_pkg::EV_TAKEN] = 1'b1;
              end
            end
            else
            begin
              ev[cfh_pkg::EV_IGNORED] = 1'b1;
            end
          end
        end
        cfh_pkg::SEL_READBACK,
        cfh_pkg::SEL_STATE:
        begin
          // requests carry no broadcast bit, so they must name us
          if (rx_len == cfh_pkg::LEN_REQUEST && addressed)
          begin
            if (r.tx_state == cfh_pkg::TX_IDLE)
            begin
              next_r.tx_buf = '0;
              next_r.tx_buf[1] = header_byte_two;
              if (config_frame_selector == cfh_pkg::SEL_READBACK)
              begin
                next_r.tx_buf[2] = {ee_wp, eeprom_status_code,
                                    2'h0, eeprom_device_select};
                next_r.tx_buf[3] = eeprom_byte_pointer;
                for (int i = 0; i < 8; i++)
                begin
                  next_r.tx_buf[4 + i] = ee_bytes[8*i +: 8];
                end
                next_r.tx_len = cfh_pkg::LEN_READBACK;
              end
              else
              begin
                // tally already includes this request
                next_r.tx_buf[2] = {r.tally + 4'h1, op_code};
                next_r.tx_len = cfh_pkg::LEN_STATE;
              end
              next_r.tx_state = cfh_pkg::TX_SEND;
              next_r.tx_valid = 1'b1;
              next_r.tx_data = header_byte_one;
              next_r.tx_last = 1'b0;
              next_r.tx_idx = 4'h1;
            end
            else
            begin
              ev[cfh_pkg::EV_IGNORED] = 1'b1;
            end
          end
        end
        default:
        begin
          next_r.taken = 1'b0;
        end
      endcase
    end

    next_r.irq = |(ev_flag & r.irq_en);
  end

  generate
    for (genvar g = 0; g < cfh_pkg::NUM_EVENTS; g++)
    begin : g_ev
      sticky_event_bit u_bit
      (
        .pclk        (pclk),
        .presetn     (presetn),
        .clk_en      (clk_en),
        .set_pulse   (ev[g]),
        .clear_pulse (ev_clear[g]),
        .flag        (ev_flag[g])
      );
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.enable <= cfh_pkg::RST_ENABLE;
      r.node_addr <= cfh_pkg::RST_NODE;
      r.threshold <= cfh_pkg::RST_THRESH;
      r.tx_state <= cfh_pkg::TX_IDLE;
    end
    else if (clk_en)
    begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign tx_valid = r.tx_valid;
  assign tx_data = r.tx_data;
  assign tx_last = r.tx_last;
  assign auto_address_switch = r.aa_switch;
  assign assigned_node_address = r.node_addr;
  assign auto_address_threshold = r.threshold;
  assign address_taken = r.taken;
  assign irq = r.irq;

endmodule

// file: dv/cfh_assertions.sv
// Purpose: port-level checks of config_frame_handler
// Assumes: clk_en held high by the bench
// Notes:   bound from the bench top file
`timescale 1ns/10ps

module cfh_assertions
#(
  parameter int ADDR_W = 12
)
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              rx_valid,
  input wire logic              rx_last,
  input wire logic              rx_good,
  input wire logic              tx_valid,
  input wire logic [7:0]        tx_data,
  input wire logic              tx_last,
  input wire logic              tx_ready,
  input wire logic [3:0]        mode_index,
  input wire logic              auto_address_switch,
  input wire logic [4:0]        assigned_node_address,
  input wire logic [7:0]        auto_address_threshold,
  input wire logic              address_taken
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence

  a_ready_after_setup: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_switch_otp_only: assert property ($changed(auto_address_switch) |->
    $past(rx_valid && rx_last && rx_good && mode_index == 4'h1))
    else $error("switch moved outside otp setup frame");
  a_taken_aa_only: assert property (address_taken |->
    $past(rx_valid && rx_last && rx_good && mode_index == 4'h2))
    else $error("address taken outside auto addressing");
  a_taken_pulse: assert property (address_taken |=> !address_taken)
    else $error("address taken longer than one cycle");
  a_thresh_cause: assert property ($changed(auto_address_threshold) |->
    $past(rx_valid && rx_last && rx_good && mode_index == 4'h2))
    else $error("threshold moved without assign frame");
  a_node_cause: assert property ($changed(assigned_node_address) |->
    $past(rx_valid && rx_last && rx_good && mode_index == 4'h2) ||
    $past(psel && penable && pready && pwrite && paddr == 12'h004))
    else $error("node address moved without cause");
  a_reply_after_req: assert property ($rose(tx_valid) |->
    $past(rx_valid && rx_last && rx_good) && tx_data[7:5] == 3'b011
    && !tx_last)
    else $error("reply not opened by header after request");
  a_tx_held: assert property (s_stall |=>
    tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("tx byte changed while stalled");
endmodule

// file: dv/host_model.sv
// Purpose: host and framer side, sends frames and takes replies
// Assumes: crc stripped, rx_good stands for a good crc
// Notes:   slow mode drops tx_ready every other cycle
`timescale 1ns/10ps

module host_model
(
  input wire logic       pclk,
  input wire logic       presetn,
  output logic           rx_valid,
  output logic [7:0]     rx_data,
  output logic           rx_last,
  output logic           rx_good,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_last,
  output logic           tx_ready
);
  logic       slow = 1'b0;
  logic [8:0] got[$];

  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_last  = 1'b0;
    rx_good  = 1'b0;
  end

  // msb byte first: header, selector, data1, data2
  task automatic send(input logic [31:0] w, input int n, input logic good);
    for (int i = 0; i < n; i++)
    begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_data  <= w[31-8*i -: 8];
      rx_last  <= (i == n - 1);
      rx_good  <= (i == n - 1) && good;
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data; // idle bus must not repeat the last byte
    rx_last  <= 1'b0;
    rx_good  <= 1'b0;
  endtask

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      tx_ready <= 1'b0;
    else
      tx_ready <= slow ? ~tx_ready : 1'b1;

  always @(posedge pclk)
    if (tx_valid && tx_ready)
      got.push_back({tx_last, tx_data});
endmodule

// file: dv/tb_config_frame_handler.sv
// Purpose: self-checking bench for config_frame_handler
// Assumes: clk_en held high, host_model on the frame side
// Notes:   expectations built from the frame layouts
`timescale 1ns/10ps

module tb_config_frame_handler;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, e, aa_sw, taken, irq;
  logic        rx_valid, rx_last, rx_good, tx_valid, tx_last, tx_ready;
  logic [7:0]  rx_data, tx_data, thr_out;
  logic        ee_busy = 1'b0, ee_denied = 1'b0, ee_failed = 1'b0;
  logic        ee_wp = 1'b0;
  logic [2:0]  dsel = 3'h0;
  logic [7:0]  eptr = 8'h00, aa_level = 8'h00;
  logic [63:0] ee_bytes = 64'h0;
  logic [3:0]  mode = 4'h0;
  logic [4:0]  node_out, node = 5'h00;
  int          err_count = 0, n_compared = 0, tally = 0;
  logic [3:0]  mi[12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                          4'h8, 4'h9, 4'ha, 4'hb};
  logic [3:0]  oc[12] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'hc,
                          4'hd, 4'he, 4'hf, 4'h0};

  config_frame_handler config_frame_handler_inst (.pclk, .presetn,
    .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_valid, .rx_data, .rx_last, .rx_good, .tx_valid,
    .tx_data, .tx_last, .tx_ready, .ee_busy, .ee_denied, .ee_failed, .ee_wp,
    .eeprom_device_select(dsel), .eeprom_byte_pointer(eptr), .ee_bytes,
    .mode_index(mode), .aa_level, .auto_address_switch(aa_sw),
    .assigned_node_address(node_out), .auto_address_threshold(thr_out),
    .address_taken(taken), .irq);

  host_model host_model_inst (.pclk, .presetn, .rx_valid, .rx_data,
    .rx_last, .rx_good, .tx_valid, .tx_data, .tx_last, .tx_ready);

  initial forever #2.5 pclk = ~pclk;

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask

  // pready, pslverr and prdata taken at the same rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    e = pslverr;
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string s, input logic [11:0] a,
                      input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(s, q, exp);
  endtask

  task automatic frame(input logic [4:0] to, sel, input logic [15:0] d,
                       input int n, input logic good);
    host_model_inst.send({3'b011, to, 3'b000, sel, d}, n, good);
    if (good)
      tally++;
    repeat (2) @(posedge pclk);
  endtask

  task automatic resp(input int n);
    for (int k = 0; k < 600 && host_model_inst.got.size() < n; k++)
      @(posedge pclk);
    chk("reply length", 32'(host_model_inst.got.size()), 32'(n));
  endtask

  task automatic bchk(input int i, input logic [8:0] exp);
    chk("reply byte", {23'h0, host_model_inst.got[i]}, {23'h0, exp});
  endtask

  task automatic state_req(input logic [3:0] code);
    host_model_inst.got.delete();
    frame(node, 5'h06, 16'h0, 2, 1'b1);
    resp(3);
    bchk(0, {4'h3, node});
    bchk(1, 9'h006);
    bchk(2, {1'b1, tally[3:0], code});
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    end_of_test();
  end

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctrl", 12'h000, 32'h1);
    rchk("node", 12'h004, 32'h0);
    rchk("unmapped", 12'h020, 32'h0);
    chk("slverr", {31'h0, e}, 32'h1);
    apb(1'b1, 12'h008, 32'h55);
    rchk("thresh ro", 12'h008, 32'h0);
    node = 5'h03;
    apb(1'b1, 12'h004, 32'h3);
    rchk("node rw", 12'h004, 32'h3);
    apb(1'b1, 12'h014, 32'h1f);
    apb(1'b1, 12'h018, 32'h1);
    // two laps so the tally wraps
    for (int r = 0; r < 24; r++)
    begin
      mode <= mi[r % 12];
      state_req(oc[r % 12]);
    end
    chk("irq set", {31'h0, irq}, 32'h1);
    rchk("irq status", 12'h010, 32'h11);
    apb(1'b1, 12'h014, 32'h1f);
    repeat (2) @(posedge pclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b1, 12'h018, 32'h0);
    frame(5'h1f, 5'h06, 16'h0, 2, 1'b0);
    frame(5'h1f, 5'h06, 16'h0, 2, 1'b1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rchk("masked status", 12'h010, 32'h1);
    state_req(4'h0);
    host_model_inst.slow <= 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      ee_busy   <= (s < 2);
      ee_denied <= (s == 0);
      ee_failed <= (s == 3);
      ee_wp     <= s[0];
      dsel      <= 3'(s + 1);
      eptr      <= 8'(8'h10 + s);
      ee_bytes  <= {8{8'(8'h20 + s)}} + 64'h0706050403020100;
      host_model_inst.got.delete();
      frame(node, 5'h03, 16'h0, 2, 1'b1);
      resp(12);
      bchk(1, 9'h003);
      bchk(2, {1'b0, s[0], 2'(s), 2'b00, 3'(s + 1)});
      bchk(3, {1'b0, 8'(8'h10 + s)});
      for (int i = 0; i < 8; i++)
        bchk(4 + i, {i == 7, ee_bytes[8*i +: 8]});
    end
    host_model_inst.slow <= 1'b0;
    mode <= 4'h3;
    frame(node, 5'h04, 16'h0100, 3, 1'b1);
    chk("aa in direct", {31'h0, aa_sw}, 32'h0);
    mode <= 4'h1;
    frame(5'h1f, 5'h04, 16'h8100, 3, 1'b1);
    chk("aa broadcast", {31'h0, aa_sw}, 32'h1);
    frame(5'h1f, 5'h04, 16'h0000, 3, 1'b1);
    chk("aa other node", {31'h0, aa_sw}, 32'h1);
    frame(node, 5'h04, 16'h0000, 3, 1'b1);
    chk("aa off", {31'h0, aa_sw}, 32'h0);
    frame(node, 5'h05, 16'h0920, 4, 1'b1);
    chk("assign in otp", {27'h0, node_out}, {27'h0, node});
    mode <= 4'h2;
    aa_level <= 8'h40;
    frame(node, 5'h05, 16'h0a41, 4, 1'b1);
    chk("thresh kept", {24'h0, thr_out}, 32'h41);
    chk("below thresh", {27'h0, node_out}, {27'h0, node});
    frame(5'h1f, 5'h05, 16'h8940, 4, 1'b1);
    node = 5'h09;
    chk("addr taken", {27'h0, node_out}, 32'h9);
    rchk("thresh reg", 12'h008, 32'h40);
    state_req(4'h2);
    rchk("status", 12'h00c, {19'h0, 3'h4, 2'h3, tally[3:0], 4'h2});
    end_of_test();
  end
endmodule

bind config_frame_handler cfh_assertions #(.ADDR_W(ADDR_W))
  cfh_assertions_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pready, .pslverr, .rx_valid, .rx_last, .rx_good, .tx_valid, .tx_data,
  .tx_last, .tx_ready, .mode_index, .auto_address_switch,
  .assigned_node_address, .auto_address_threshold, .address_taken);
